// ---- hdl/sbsr_status_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module sbsr_status_regs #(
  parameter int SYNC_STAGES = 2
) (
  // Clock, reset and enable.
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic                        clk_en,
  // Device-level reset events.
  input  wire logic                        soft_rst,
  input  wire logic                        restart,
  // Fault detectors and bridge configuration.
  input  wire sbsr_pkg::sbsr_fault_type    fault_event,
  input  wire sbsr_pkg::sbsr_bridge_cfg_type bridge_cfg,
  // Raw levels from the pins and bridge comparators.
  input  wire logic [5:0]                  pwm_in_level,
  input  wire logic [2:0]                  bridge_out_level,
  // Register read port.
  input  wire logic                        rd_en,
  input  wire logic [6:0]                  rd_addr,
  output logic                             rd_valid,
  output logic [15:0]                      rd_data
);
  import sbsr_pkg::*;

  // A single flop would hand metastable pin levels straight to the host.
  if (SYNC_STAGES < 2) begin : g_bad_sync_stages
    $error("SYNC_STAGES must be at least 2");
  end

  logic [15:0]      high_side_fault_status;
  logic [15:0]      bridge_general_status;
  logic [8:0]       lvl_pipe [SYNC_STAGES];
  logic [8:0]       lvl_sync;
  logic [15:0]      fault_vec;
  logic             hs_read;
  logic [2:0]       bridge_valid;
  logic [1:0]       mode_sel [3];
  logic [15:0]      next_high_side_fault_status;
  logic [15:0]      next_bridge_general_status;

  // Synchroniser chain: only the next stage reads each earlier stage.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        lvl_pipe[i] <= '0;
      end
    end else if (clk_en) begin
      lvl_pipe[0] <= {bridge_out_level, pwm_in_level};
      for (int i = 1; i < SYNC_STAGES; i++) begin
        lvl_pipe[i] <= lvl_pipe[i-1];
      end
    end
  end
  assign lvl_sync = lvl_pipe[SYNC_STAGES-1];

  assign fault_vec = (16'(fault_event.overtemp)    << SBSR_HS_OT_LSB)
                   | (16'(fault_event.open_load)   << SBSR_HS_OL_LSB)
                   | (16'(fault_event.overcurrent) << SBSR_HS_OC_LSB);
  assign hs_read   = rd_en && (rd_addr == SBSR_ADDR_HS_FAULT);

  // Set beats clear, so a fault in the reading cycle survives.
  always_comb begin
    next_high_side_fault_status = high_side_fault_status;
    if (hs_read) begin
      next_high_side_fault_status = '0;
    end
    next_high_side_fault_status = next_high_side_fault_status | fault_vec;
    if (restart) begin
      next_high_side_fault_status = next_high_side_fault_status & SBSR_HS_RESTART_KEEP;
    end
    if (soft_rst) begin
      next_high_side_fault_status = SBSR_RESET_VALUE;
    end
    next_high_side_fault_status = next_high_side_fault_status & SBSR_HS_USED_MASK;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      high_side_fault_status <= SBSR_RESET_VALUE;
    end else if (clk_en) begin
      high_side_fault_status <= next_high_side_fault_status;
    end
  end

  assign mode_sel[0] = bridge_cfg.mode1;
  assign mode_sel[1] = bridge_cfg.mode2;
  assign mode_sel[2] = bridge_cfg.mode3;
  for (genvar b = 0; b < 3; b++) begin : g_bridge
    assign bridge_valid[b] = bridge_cfg.charge_pump_on
                          && (mode_sel[b] == SBSR_BRIDGE_SENSE_MODE);
  end

  // The general word is a live snapshot; restart freezes the kept bits.
  always_comb begin
    next_bridge_general_status = '0;
    next_bridge_general_status[SBSR_GEN_BRIDGE_LSB +: 3] = lvl_sync[8:6] & bridge_valid;
    next_bridge_general_status[SBSR_GEN_PWM_LSB +: 6]    = lvl_sync[5:0];
    if (restart) begin
      next_bridge_general_status = bridge_general_status & SBSR_GEN_RESTART_KEEP;
    end
    if (soft_rst) begin
      next_bridge_general_status = SBSR_RESET_VALUE;
    end
    next_bridge_general_status = next_bridge_general_status & SBSR_GEN_USED_MASK;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bridge_general_status <= SBSR_RESET_VALUE;
    end else if (clk_en) begin
      bridge_general_status <= next_bridge_general_status;
    end
  end

  // Read answer one cycle after the request; unmapped addresses read zero.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= SBSR_RESET_VALUE;
    end else if (clk_en) begin
      rd_valid <= rd_en;
      if (hs_read) begin
        rd_data <= high_side_fault_status;
      end else if (rd_en && (rd_addr == SBSR_ADDR_BRIDGE_GENERAL_STATUS)) begin
        rd_data <= bridge_general_status;
      end else if (rd_en) begin
        rd_data <= SBSR_RESET_VALUE;
      end
    end
  end

  a_ot_flag_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && fault_event.overtemp[2] && !soft_rst |=> high_side_fault_status[12])
    else $error("overtemp flag of output three not set");

  a_ol_flag_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && fault_event.open_load[0] && !soft_rst |=> high_side_fault_status[5])
    else $error("open-load flag of output one not set");

  a_oc_flag_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && fault_event.overcurrent[1] && !soft_rst |=> high_side_fault_status[1])
    else $error("overcurrent flag of output two not set");

  a_read_clears_flags: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && hs_read && (fault_vec == 16'h0000)
      |=> rd_valid && (high_side_fault_status == 16'h0000)
          && (rd_data == $past(high_side_fault_status)))
    else $error("fault word not returned then cleared by read");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ((high_side_fault_status & 16'hE318) == 16'h0000)
      && ((bridge_general_status & 16'hFE00) == 16'h0000))
    else $error("reserved status bit set");

  a_soft_reset_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && soft_rst |=> (high_side_fault_status == 16'h0000)
      && (bridge_general_status == 16'h0000))
    else $error("soft reset did not clear status");

  a_restart_keeps_faults: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && restart && !soft_rst && !hs_read && (fault_vec == 16'h0000)
      |=> $stable(high_side_fault_status))
    else $error("restart disturbed fault flags");

  a_restart_gen_word: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && restart && !soft_rst
      |=> bridge_general_status == ($past(bridge_general_status) & 16'h00C1))
    else $error("restart did not clear general word correctly");

  a_bridge_level_live: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && !restart && !soft_rst && bridge_cfg.charge_pump_on
      && (bridge_cfg.mode2 == 2'h3) && lvl_sync[7] |=> bridge_general_status[7])
    else $error("bridge two level not reported");

  a_bridge_level_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && !restart && (!bridge_cfg.charge_pump_on || (bridge_cfg.mode3 != 2'h3))
      |=> !bridge_general_status[8])
    else $error("bridge three level set while invalid");

  a_pwm_mirror: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en
      ##1 clk_en && !restart && !soft_rst
      ##1 clk_en && !restart && !soft_rst
      |=> bridge_general_status[5:0] == $past(pwm_in_level, 3))
    else $error("PWM levels not mirrored after synchroniser");

  a_set_beats_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && hs_read && fault_event.overcurrent[0] && !soft_rst
      |=> high_side_fault_status[0])
    else $error("fault lost in clearing read");

  a_bridge_level_low: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && !restart && !soft_rst && bridge_cfg.charge_pump_on
      && (bridge_cfg.mode1 == 2'h3) && !lvl_sync[6] |=> !bridge_general_status[6])
    else $error("bridge one level high while output low");

  a_gen_read_returns: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && rd_en && (rd_addr == SBSR_ADDR_BRIDGE_GENERAL_STATUS)
      |=> rd_valid && (rd_data == $past(bridge_general_status)))
    else $error("general word not returned by read");

  a_gen_read_harmless: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && rd_en && (rd_addr == SBSR_ADDR_BRIDGE_GENERAL_STATUS)
      && !soft_rst && (fault_vec == 16'h0000) |=> $stable(high_side_fault_status))
    else $error("general word read disturbed fault flags");

endmodule // sbsr_status_regs
`default_nettype wire

// ---- hdl/sbsr_pkg.sv ----
package sbsr_pkg;

  // Register indices on the serial register port.
  localparam logic [6:0]  SBSR_ADDR_HS_FAULT  = 7'h46;
  localparam logic [6:0]  SBSR_ADDR_BRIDGE_GENERAL_STATUS  = 7'h50;
  localparam int          SBSR_ADDR_W         = 7;
  localparam int          SBSR_DATA_W         = 16;

  // Field positions in high_side_fault_status.
  localparam int          SBSR_HS_OT_LSB      = 10;
  localparam int          SBSR_HS_OL_LSB      = 5;
  localparam int          SBSR_HS_OC_LSB      = 0;
  localparam logic [15:0] SBSR_HS_USED_MASK   = 16'h1CE7;
  localparam logic [15:0] SBSR_HS_RESTART_KEEP = 16'h3FFF;

  // Field positions in bridge_general_status.
  localparam int          SBSR_GEN_BRIDGE_LSB = 6;
  localparam int          SBSR_GEN_PWM_LSB    = 0;
  localparam logic [15:0] SBSR_GEN_USED_MASK  = 16'h01FF;
  localparam logic [15:0] SBSR_GEN_RESTART_KEEP = 16'h00C1;

  localparam logic [15:0] SBSR_RESET_VALUE    = 16'h0000;
  localparam logic [1:0]  SBSR_BRIDGE_SENSE_MODE = 2'h3;

  // One detector pulse per high-side output, index 0 is output one.
  typedef struct packed {
    logic [2:0] overtemp;
    logic [2:0] open_load;
    logic [2:0] overcurrent;
  } sbsr_fault_type;

  // Bridge configuration seen by the level-report logic.
  typedef struct packed {
    logic       charge_pump_on;
    logic [1:0] mode3;
    logic [1:0] mode2;
    logic [1:0] mode1;
  } sbsr_bridge_cfg_type;

endpackage

// ---- verification/sbsr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sbsr_host_model (
  // Clock.
  input  wire logic        ref_clk,
  // Device read port.
  output logic             rd_en,
  output logic [6:0]       rd_addr,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data
);
  initial begin
    rd_en   = 1'b0;
    rd_addr = 7'h00;
  end
  // One request per call; the answer is taken at the edge that samples rd_valid high.
  task automatic read_word(input logic [6:0] addr, output logic [15:0] data);
    @(posedge ref_clk);
    rd_en   <= 1'b1;
    rd_addr <= addr;
    @(posedge ref_clk);
    rd_en   <= 1'b0;
    rd_addr <= ~addr; // A released index must not look like the old one.
    @(posedge ref_clk);
    data = rd_valid ? rd_data : 16'hxxxx;
  endtask
endmodule // sbsr_host_model
`default_nettype wire

// ---- verification/test_sbsr_status_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_sbsr_status_regs;
  import sbsr_pkg::*;
  typedef struct packed {logic [8:0] ev; logic [15:0] exp;} sbsr_row_type;
  logic                ref_clk = 1'b0;
  logic                arst_n = 1'b0;
  logic                soft_rst = 1'b0;
  logic                restart = 1'b0;
  logic                clk_en = 1'b1;
  sbsr_fault_type      fault_event = '0;
  sbsr_bridge_cfg_type bridge_cfg = '0;
  logic [5:0]          pwm_in_level = 6'h00;
  logic [2:0]          bridge_out_level = 3'h0;
  logic                rd_en;
  logic                rd_valid;
  logic [6:0]          rd_addr;
  logic [15:0]         rd_data;
  logic [15:0]         got;
  int                  bad_count = 0;
  int                  cmp_count = 0;
  int                  cycles = 0;
  // Fault pulse beside the fault word it should leave.
  sbsr_row_type rows [5] = '{{9'h1C0, 16'h1C00}, {9'h038, 16'h00E0}, {9'h007, 16'h0007},
                             {9'h124, 16'h1084}, {9'h1FF, 16'h1CE7}};
  always #4 ref_clk = ~ref_clk;
  sbsr_status_regs #(.SYNC_STAGES(2)) i_sbsr_status_regs (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .soft_rst(soft_rst),
    .restart(restart), .fault_event(fault_event), .bridge_cfg(bridge_cfg),
    .pwm_in_level(pwm_in_level), .bridge_out_level(bridge_out_level),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));
  sbsr_host_model i_sbsr_host_model (
    .ref_clk(ref_clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_valid(rd_valid),
    .rd_data(rd_data));
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw 0x%h, wanted 0x%h", $time, seen, exp);
    end
  endtask
  task automatic rd_check(input logic [6:0] addr, input logic [15:0] exp);
    i_sbsr_host_model.read_word(addr, got);
    check(got, exp);
  endtask
  // Levels need the synchroniser plus one cycle, so six is ample.
  task automatic set_levels(input logic [6:0] cfg, input logic [5:0] pwm, input logic [2:0] lvl);
    @(posedge ref_clk);
    bridge_cfg       <= cfg;
    pwm_in_level     <= pwm;
    bridge_out_level <= lvl;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic pulse_faults(input logic [8:0] ev);
    @(posedge ref_clk);
    fault_event <= ev;
    @(posedge ref_clk);
    fault_event <= '0;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    check(rd_data, 16'h0000);
    arst_n <= 1'b1;
    rd_check(SBSR_ADDR_HS_FAULT, 16'h0000);
    rd_check(SBSR_ADDR_BRIDGE_GENERAL_STATUS, 16'h0000);
    foreach (rows[i]) begin
      pulse_faults(rows[i].ev);
      rd_check(SBSR_ADDR_HS_FAULT, rows[i].exp);
      rd_check(SBSR_ADDR_HS_FAULT, 16'h0000);
    end
    // The fault is still high on the edge that takes the clearing read.
    @(posedge ref_clk);
    fault_event <= 9'h001;
    fork
      i_sbsr_host_model.read_word(SBSR_ADDR_HS_FAULT, got);
      begin
        repeat (2) @(posedge ref_clk);
        fault_event <= '0;
      end
    join
    check(got, 16'h0001);
    rd_check(SBSR_ADDR_HS_FAULT, 16'h0001);
    rd_check(SBSR_ADDR_HS_FAULT, 16'h0000);
    set_levels(7'h7D, 6'h2A, 3'h7);
    rd_check(SBSR_ADDR_BRIDGE_GENERAL_STATUS, 16'h01AA);
    rd_check(SBSR_ADDR_BRIDGE_GENERAL_STATUS, 16'h01AA);
    rd_check(7'h47, 16'h0000);
    set_levels(7'h3F, 6'h15, 3'h7);
    rd_check(SBSR_ADDR_BRIDGE_GENERAL_STATUS, 16'h0015);
    // Only bridge two is high, so bridges one and three must read low.
    set_levels(7'h7F, 6'h00, 3'h2);
    rd_check(SBSR_ADDR_BRIDGE_GENERAL_STATUS, 16'h0080);
    set_levels(7'h7F, 6'h3F, 3'h7);
    rd_check(SBSR_ADDR_BRIDGE_GENERAL_STATUS, 16'h01FF);
    pulse_faults(9'h1FF);
    restart <= 1'b1;
    rd_check(SBSR_ADDR_BRIDGE_GENERAL_STATUS, 16'h00C1);
    rd_check(SBSR_ADDR_HS_FAULT, 16'h1CE7);
    restart <= 1'b0;
    pulse_faults(9'h1FF);
    soft_rst <= 1'b1;
    @(posedge ref_clk);
    soft_rst <= 1'b0;
    rd_check(SBSR_ADDR_HS_FAULT, 16'h0000);
    // A frozen block must not take a fault pulse.
    clk_en <= 1'b0;
    pulse_faults(9'h1FF);
    clk_en <= 1'b1;
    rd_check(SBSR_ADDR_HS_FAULT, 16'h0000);
    // An asynchronous reset in mid-run must wipe pending flags too.
    pulse_faults(9'h1FF);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd_check(SBSR_ADDR_HS_FAULT, 16'h0000);
    wrap_up();
  end
endmodule // test_sbsr_status_regs
`default_nettype wire
